/* ebct_defines.vh */
// constants for the external bus cycle timing block
`ifndef EBCT_DEFINES_VH
`define EBCT_DEFINES_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define EBCT_OFS_CFG0 8'h00
`define EBCT_OFS_CFG1 8'h04
`define EBCT_OFS_CFG2 8'h08
`define EBCT_OFS_CFG3 8'h0C
`define EBCT_OFS_CFG4 8'h10
`define EBCT_OFS_STAT 8'h14

// ************************************************************
// bus configuration field positions
// ************************************************************
`define EBCT_F_WAIT_LO 0
`define EBCT_F_WAIT_HI 3
`define EBCT_F_CMDDLY 4
`define EBCT_F_FLOAT 5
`define EBCT_F_MUX 7
`define EBCT_F_STRETCH 9
`define EBCT_F_HSEN 12
`define EBCT_CFG_MASK 16'h12BF

// ************************************************************
// reset values
// ************************************************************
`define EBCT_RST_CFG0 16'h0280
`define EBCT_RST_CFGX 16'h0000

// ************************************************************
// timing
// ************************************************************
`define EBCT_SYNC_EXTRA 4'h2

`endif

/* ebct_rdy_sync.v */
// two-stage synchroniser for the ready pin
`timescale 1ns/1ps
module ebct_rdy_sync (
  input wire CLK_SYS,
  input wire RST_N,
  input wire d,
  output wire q
);
  reg s1_ff;
  reg s2_ff;
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
    end
  end
  assign q = s2_ff;
endmodule // ebct_rdy_sync

/* ebct_top.v */
// external bus cycle timing engine with axi4-lite configuration
// Operation
// R01: stretch bit lengthens strobe by half clock
// R02: stretch also holds address, shifts transfer; the code adds the address hold phase only when mux is also set
// R03: default stretch resets one, windows zero
// R04: insert fifteen minus field wait states
// R05: stall cpu during access wait states
// R06: float bit zero adds one idle state
// R07: idle state alone never stalls cpu
// R08: multiplexed mode adds implicit idle state
// R09: delay bit zero delays command half clock
// R10: command delay never lengthens the cycle
// R11: software should delay commands on multiplexed
// R12: internal full speed, external slowest at reset
// R13: handshake uses low three wait bits
// R14: top wait bit selects ready mode
// R15: async ready adds synchroniser wait states
// R16: peripheral drives ready low when done
// R17: peripheral may release ready on command rise
// R18: handshake cycle waits for ready forever
// R19: software enables clock output for sync ready
// R20: ready at first sample ends cycle
// R21: software programs waits for normally ready parts
// R22: accesses outside windows use default config
// R23: cycle machine runs in half clock phases
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ebct_defines.vh"
module ebct_top (
  input wire CLK_SYS,
  input wire RST_N,
  input wire [31:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output wire [1:0] S_AXI_BRESP,
  output wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [31:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output wire [31:0] S_AXI_RDATA,
  output wire [1:0] S_AXI_RRESP,
  output wire S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire REQ_VALID,
  input wire REQ_EXTERNAL,
  input wire [3:0] REQ_WINDOW,
  input wire REQ_WRITE,
  input wire REQ_NEEDED,
  output wire REQ_READY,
  output wire CPU_STALL,
  output wire BUS_BUSY,
  output wire STROBE,
  output wire ADDR_DRIVE,
  output wire CMD_RD_N,
  output wire CMD_WR_N,
  input wire READY_N
);
  // ************************************************************
  // phases, one-hot
  // ************************************************************
  localparam [7:0] ST_IDLE = 8'h01;
  localparam [7:0] ST_ALE = 8'h02;
  localparam [7:0] ST_AHOLD = 8'h04;
  localparam [7:0] ST_WAIT = 8'h08;
  localparam [7:0] ST_RDY = 8'h10;
  localparam [7:0] ST_END = 8'h20;
  localparam [7:0] ST_FLOAT = 8'h40;
  localparam [7:0] ST_INT = 8'h80;

  // ************************************************************
  // axi4-lite slave
  // ************************************************************
  reg [15:0] cfg_ff [0:4];
  reg aw_ff;
  reg w_ff;
  reg [31:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0] rresp_ff;
  reg [7:0] st_ff;
  reg ready_seen_ff;
  wire do_wr = aw_ff && w_ff && !bvalid_ff;
  wire [7:0] wofs = awaddr_ff[7:0];
  wire wsel_ok = (awaddr_ff[31:8] == 24'h000000) && (wofs[1:0] == 2'b00) &&
                 (wofs <= `EBCT_OFS_CFG4);
  wire [2:0] widx = wofs[4:2];
  wire [7:0] rofs = S_AXI_ARADDR[7:0];
  wire rsel_hi = (S_AXI_ARADDR[31:8] == 24'h000000) && (rofs[1:0] == 2'b00);
  assign S_AXI_AWREADY = !aw_ff;
  assign S_AXI_WREADY = !w_ff;
  assign S_AXI_BVALID = bvalid_ff;
  assign S_AXI_BRESP = bresp_ff;
  assign S_AXI_ARREADY = !rvalid_ff;
  assign S_AXI_RVALID = rvalid_ff;
  assign S_AXI_RDATA = rdata_ff;
  assign S_AXI_RRESP = rresp_ff;

  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 32'h00000000;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'b00;
    end else begin
      if (S_AXI_AWVALID && !aw_ff) begin
        aw_ff <= 1'b1;
        awaddr_ff <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_ff) begin
        w_ff <= 1'b1;
        wdata_ff <= S_AXI_WDATA;
        wstrb_ff <= S_AXI_WSTRB;
      end
      if (do_wr) begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wsel_ok ? 2'b00 : 2'b10;
      end else if (bvalid_ff && S_AXI_BREADY) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // mask as a sized vector so each byte lane takes only its own eight bits
  wire [15:0] cfg_mask = `EBCT_CFG_MASK;
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_cfg
      // default config resets to the slowest cycle, windows to zero
      always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
          cfg_ff[gi] <= (gi == 0) ? `EBCT_RST_CFG0 : `EBCT_RST_CFGX; // R03 R12
        end else if (do_wr && wsel_ok && widx == gi) begin
          if (wstrb_ff[0])
            cfg_ff[gi][7:0] <= wdata_ff[7:0] & cfg_mask[7:0];
          if (wstrb_ff[1])
            cfg_ff[gi][15:8] <= wdata_ff[15:8] & cfg_mask[15:8];
        end
      end
    end
  endgenerate

  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= 2'b00;
    end else if (S_AXI_ARVALID && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= 2'b00;
      if (rsel_hi && rofs <= `EBCT_OFS_CFG4)
        rdata_ff <= {16'h0000, cfg_ff[rofs[4:2]]};
      else if (rsel_hi && rofs == `EBCT_OFS_STAT)
        rdata_ff <= {23'h000000, ready_seen_ff, st_ff};
      else begin
        rdata_ff <= 32'h00000000;
        rresp_ff <= 2'b10;
      end
    end else if (rvalid_ff && S_AXI_RREADY) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ************************************************************
  // window selection and config latch
  // ************************************************************
  reg [2:0] wsel;
  always @* begin
    wsel = 3'd0; // R22
    if (REQ_WINDOW[3]) wsel = 3'd4;
    else if (REQ_WINDOW[2]) wsel = 3'd3;
    else if (REQ_WINDOW[1]) wsel = 3'd2;
    else if (REQ_WINDOW[0]) wsel = 3'd1;
  end

  reg [15:0] cur_ff;
  reg write_ff;
  reg need_ff;
  reg [4:0] cnt_ff;
  wire [3:0] wfield = cur_ff[`EBCT_F_WAIT_HI:`EBCT_F_WAIT_LO];
  wire hs_en = cur_ff[`EBCT_F_HSEN];
  wire async_rdy = wfield[3];
  wire stretch = cur_ff[`EBCT_F_STRETCH];
  wire mux = cur_ff[`EBCT_F_MUX];
  wire cmd_early = cur_ff[`EBCT_F_CMDDLY];
  wire float_off = cur_ff[`EBCT_F_FLOAT];

  // ************************************************************
  // ready sampling
  // ************************************************************
  reg rdy_sync_smp_ff;
  wire rdy_async;
  ebct_rdy_sync u_sync (
    .CLK_SYS(CLK_SYS),
    .RST_N(RST_N),
    .d(READY_N),
    .q(rdy_async)
  );
  // sync mode still needs two flops since the pin is foreign to this clock
  reg rs1_ff;
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rs1_ff <= 1'b1;
      rdy_sync_smp_ff <= 1'b1;
    end else begin
      rs1_ff <= READY_N;
      rdy_sync_smp_ff <= rs1_ff;
    end
  end
  wire rdy_act = async_rdy ? !rdy_async : !rdy_sync_smp_ff; // R14

  // ************************************************************
  // cycle state machine, half-clock phases
  // ************************************************************
  reg [7:0] nxt_st;
  reg [4:0] nxt_cnt;
  reg cmd_on_ff;
  reg nxt_cmd_on;
  wire [4:0] wait_n = hs_en ? {2'b00, wfield[2:0]} : // R13
                      {1'b0, 4'hF - wfield}; // R04
  wire [4:0] flt_n = {4'h0, !float_off} + {4'h0, mux}; // R06 R08

  always @* begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_cmd_on = cmd_on_ff;
    case (st_ff)
      ST_IDLE: begin
        if (REQ_VALID && !REQ_EXTERNAL) nxt_st = ST_INT; // R12
        else if (REQ_VALID) begin
          nxt_st = ST_ALE;
          nxt_cnt = 5'd0;
        end
      end
      ST_INT: nxt_st = ST_IDLE;
      ST_ALE: begin
        // two half phases normally, three when stretched
        nxt_cnt = cnt_ff + 5'd1; // R23
        if (cnt_ff == (stretch ? 5'd2 : 5'd1)) begin // R01
          nxt_st = ST_AHOLD;
          nxt_cnt = 5'd0;
          nxt_cmd_on = cmd_early; // R09
        end
      end
      ST_AHOLD: begin
        nxt_cnt = cnt_ff + 5'd1;
        nxt_cmd_on = 1'b1; // R09 R10
        if (cnt_ff == ((stretch && mux) ? 5'd1 : 5'd0)) begin // R02
          nxt_cnt = 5'd0;
          nxt_st = (wait_n == 5'd0) ? (hs_en ? ST_RDY : ST_END) : ST_WAIT;
        end
      end
      ST_WAIT: begin
        nxt_cnt = cnt_ff + 5'd1;
        // each wait state is two phases, one cpu clock
        if (cnt_ff == {wait_n[3:0], 1'b0} - 5'd1) begin // R04 R13
          nxt_cnt = 5'd0;
          nxt_st = hs_en ? ST_RDY : ST_END;
        end
      end
      ST_RDY: begin
        nxt_cnt = (cnt_ff == 5'd31) ? cnt_ff : cnt_ff + 5'd1;
        // async mode waits extra phases for the synchroniser, no timeout
        if (rdy_act && (!async_rdy || cnt_ff >= {`EBCT_SYNC_EXTRA, 1'b0})) begin // R15 R18 R20
          nxt_st = ST_END;
          nxt_cnt = 5'd0;
        end
      end
      ST_END: begin
        nxt_cmd_on = 1'b0;
        nxt_cnt = 5'd0;
        nxt_st = (flt_n == 5'd0) ? ST_IDLE : ST_FLOAT;
      end
      ST_FLOAT: begin
        nxt_cnt = cnt_ff + 5'd1;
        if (cnt_ff == {flt_n[3:0], 1'b0} - 5'd1) nxt_st = ST_IDLE; // R06 R08
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      st_ff <= ST_IDLE;
      cnt_ff <= 5'd0;
      cmd_on_ff <= 1'b0;
      cur_ff <= `EBCT_RST_CFG0;
      write_ff <= 1'b0;
      need_ff <= 1'b0;
      ready_seen_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      cmd_on_ff <= nxt_cmd_on;
      if (st_ff == ST_IDLE && REQ_VALID) begin
        cur_ff <= cfg_ff[wsel]; // R22
        write_ff <= REQ_WRITE;
        need_ff <= REQ_NEEDED;
      end
      if (st_ff == ST_RDY && nxt_st == ST_END) ready_seen_ff <= 1'b1;
      else if (st_ff == ST_ALE) ready_seen_ff <= 1'b0;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  wire busy = !(st_ff == ST_IDLE) && !(st_ff == ST_FLOAT) && !(st_ff == ST_INT);
  assign REQ_READY = (st_ff == ST_IDLE); // R07
  assign CPU_STALL = busy && need_ff; // R05 R07
  assign BUS_BUSY = !(st_ff == ST_IDLE);
  assign STROBE = (st_ff == ST_ALE);
  assign ADDR_DRIVE = (st_ff == ST_ALE) || (st_ff == ST_AHOLD); // R02
  assign CMD_RD_N = !(cmd_on_ff && !write_ff); // R16 R17
  assign CMD_WR_N = !(cmd_on_ff && write_ff);
endmodule // ebct_top

/* ebct_top_monitor.sv */
// assertion checker for the external bus cycle timing engine
`timescale 1ns/1ps
module ebct_chk (
  input wire CLK_SYS,
  input wire RST_N,
  input wire REQ_VALID,
  input wire REQ_EXTERNAL,
  input wire REQ_READY,
  input wire CPU_STALL,
  input wire BUS_BUSY,
  input wire STROBE,
  input wire ADDR_DRIVE,
  input wire CMD_RD_N,
  input wire CMD_WR_N
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);
  chk_cmd_one: assert property (CMD_RD_N || CMD_WR_N)
    else $error("both commands active");
  chk_strobe_cmd: assert property (STROBE |-> CMD_RD_N && CMD_WR_N)
    else $error("command active during strobe");
  chk_ext_start: assert property (REQ_VALID && REQ_READY && REQ_EXTERNAL |=> STROBE [*2])
    else $error("strobe shorter than two phases");
  chk_int_fast: assert property (REQ_VALID && REQ_READY && !REQ_EXTERNAL |=> !STROBE)
    else $error("internal access drove strobe");
  chk_addr_hold: assert property ($fell(STROBE) |-> ADDR_DRIVE)
    else $error("address not held after strobe");
  chk_strobe_addr: assert property (STROBE |-> ADDR_DRIVE)
    else $error("address missing under strobe");
  chk_stall_busy: assert property (CPU_STALL |-> BUS_BUSY)
    else $error("stall outside a bus cycle");
  chk_cmd_busy: assert property (!(CMD_RD_N && CMD_WR_N) |-> BUS_BUSY)
    else $error("command active while idle");
  chk_strobe_max: assert property ($rose(STROBE) |-> ##3 !STROBE)
    else $error("strobe longer than three phases");
  chk_cmd_late: assert property ($fell(STROBE) |-> ##1 !(CMD_RD_N && CMD_WR_N))
    else $error("command later than one phase after strobe");
endmodule // ebct_chk
bind ebct_top ebct_chk i_chk (.*);

/* ebct_mem_model.sv */
// behavioural model of the external part answering on the ready pin
`timescale 1ns/1ps
module ebct_mem (
  input wire clk,
  input wire cmd_rd_n,
  input wire cmd_wr_n,
  input wire [7:0] dly,
  output wire ready_n
);
  logic [7:0] cnt_ff;
  wire act = !(cmd_rd_n && cmd_wr_n);
  always @(posedge clk) begin
    if (!act)
      cnt_ff <= 8'h00;
    else if (cnt_ff != 8'hFF)
      cnt_ff <= cnt_ff + 8'h01;
  end
  // released with the command edge, so the pull-up returns the line high
  // a delay of FF models a part that never answers
  assign ready_n = !(act && dly != 8'hFF && cnt_ff >= dly);
endmodule // ebct_mem

/* tb_ext_bus_cycle_timing.sv */
// self-checking bench for the external bus cycle timing engine
`timescale 1ns/1ps
`include "ebct_defines.vh"
module tb_ext_bus_cycle_timing;
  logic CLK_SYS = 1'b0, RST_N = 1'b0;
  logic [31:0] S_AXI_AWADDR = 32'h0, S_AXI_WDATA = 32'h0, S_AXI_ARADDR = 32'h0;
  logic [3:0] S_AXI_WSTRB = 4'h3, REQ_WINDOW = 4'h0;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0, REQ_VALID = 1'b0;
  logic REQ_EXTERNAL = 1'b0, REQ_WRITE = 1'b0, REQ_NEEDED = 1'b0;
  wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  wire REQ_READY, CPU_STALL, BUS_BUSY, STROBE, ADDR_DRIVE, CMD_RD_N, CMD_WR_N, READY_N;
  wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
  wire [31:0] S_AXI_RDATA;
  logic [7:0] dly = 8'h06;
  logic [15:0] cfgs [5] = '{16'h0000, 16'h003F, 16'h0290, 16'h02EF, 16'h0270};
  int n_fail = 0, total_checks = 0, s_n, b_n, st_n, cf, c_n, w_n;

  ebct_top i_dut (.*);
  ebct_mem i_mem (.clk(CLK_SYS), .cmd_rd_n(CMD_RD_N), .cmd_wr_n(CMD_WR_N), .dly(dly),
    .ready_n(READY_N));

  always #5 CLK_SYS = ~CLK_SYS;

  // ****************************************
  // shared tasks
  // ****************************************
  task chk(input [31:0] got, input [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task end_sim;
    if (n_fail == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task wr(input [7:0] a, input [31:0] d);
    logic ta, tw;
    @(posedge CLK_SYS);
    S_AXI_AWADDR <= {24'h0, a};
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(negedge CLK_SYS);
      ta = S_AXI_AWVALID && S_AXI_AWREADY;
      tw = S_AXI_WVALID && S_AXI_WREADY;
      @(posedge CLK_SYS);
      if (ta) S_AXI_AWVALID <= 1'b0;
      if (tw) S_AXI_WVALID <= 1'b0;
      #1;
    end while (S_AXI_AWVALID || S_AXI_WVALID);
    do @(negedge CLK_SYS); while (S_AXI_BVALID !== 1'b1);
    chk(S_AXI_BRESP, 2'b00);
    @(posedge CLK_SYS);
    S_AXI_BREADY <= 1'b0;
  endtask

  task rd(input [7:0] a, input [31:0] ed, input [1:0] er);
    @(posedge CLK_SYS);
    S_AXI_ARADDR <= {24'h0, a};
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do @(negedge CLK_SYS); while (S_AXI_ARREADY !== 1'b1);
    @(posedge CLK_SYS);
    S_AXI_ARVALID <= 1'b0;
    do @(negedge CLK_SYS); while (S_AXI_RVALID !== 1'b1);
    chk(S_AXI_RDATA, ed);
    chk(S_AXI_RRESP, er);
    @(posedge CLK_SYS);
    S_AXI_RREADY <= 1'b0;
  endtask

  // one access; counts strobe, busy and stall phases, and the first command phase
  task acc(input [3:0] w, input wrt, input nd, input ext);
    int k;
    @(posedge CLK_SYS);
    REQ_VALID <= 1'b1;
    REQ_WINDOW <= w;
    REQ_WRITE <= wrt;
    REQ_NEEDED <= nd;
    REQ_EXTERNAL <= ext;
    @(posedge CLK_SYS);
    REQ_VALID <= 1'b0;
    s_n = 0;
    b_n = 0;
    st_n = 0;
    cf = -1;
    c_n = 0;
    w_n = 0;
    for (k = 0; k < 300; k++) begin
      #1;
      if (BUS_BUSY !== 1'b1) break;
      b_n++;
      s_n += (STROBE === 1'b1);
      st_n += (CPU_STALL === 1'b1);
      c_n += ((CMD_RD_N & CMD_WR_N) === 1'b0);
      w_n += (CMD_WR_N === 1'b0);
      if (cf < 0 && (CMD_RD_N & CMD_WR_N) === 1'b0) cf = k;
      @(posedge CLK_SYS);
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task t_regs;
    rd(`EBCT_OFS_CFG0, 32'h0280, 2'b00);
    for (int i = 1; i < 5; i++)
      rd(8'(4 * i), 32'h0, 2'b00);
    wr(`EBCT_OFS_CFG4, 32'hFFFF_FFFF);
    rd(`EBCT_OFS_CFG4, 32'h12BF, 2'b00);
    rd(8'h18, 32'h0, 2'b10);
    rd(`EBCT_OFS_STAT, 32'h0000_0001, 2'b00);
  endtask

  task t_time(input [7:0] a, input [3:0] w, input [15:0] c, input nd);
    int e_s, e_b, fl;
    wr(a, {16'h0000, c});
    acc(w, c[6], nd, 1'b1);
    e_s = 2 + c[9];
    fl = 2 * (!c[5] + c[7]);
    e_b = e_s + 2 + (c[9] & c[7]) + 2 * (15 - c[3:0]) + fl;
    chk(s_n, e_s);
    chk(b_n, e_b);
    chk(cf - s_n, !c[4]);
    chk(st_n, nd ? e_b - fl : 0);
    chk(c_n, e_b - fl - e_s - !c[4]);
    chk(w_n != 0, c[6]);
  endtask

  task t_rdy;
    int b1;
    wr(`EBCT_OFS_CFG2, 32'h1001);
    dly = 8'h00;
    acc(4'h2, 1'b0, 1'b1, 1'b1);
    chk(b_n, 9);
    b1 = b_n;
    dly = 8'h0A;
    acc(4'h2, 1'b1, 1'b1, 1'b1);
    chk(b_n - b1, 10);
    wr(`EBCT_OFS_CFG2, 32'h1009);
    dly = 8'h00;
    acc(4'h2, 1'b0, 1'b1, 1'b1);
    chk(b_n - b1, 4);
    rd(`EBCT_OFS_STAT, 32'h0000_0101, 2'b00);
    dly = 8'hFF;
    acc(4'h2, 1'b0, 1'b1, 1'b1);
    chk(b_n, 300);
    RST_N <= 1'b0;
    repeat (3) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    dly = 8'h06;
  endtask

  initial begin
    repeat (3) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    t_regs;
    for (int i = 0; i < 5; i++)
      t_time(`EBCT_OFS_CFG1, 4'h1, cfgs[i], i != 2);
    t_time(`EBCT_OFS_CFG0, 4'h0, 16'h0280, 1'b1);
    acc(4'h1, 1'b0, 1'b1, 1'b0);
    chk(s_n, 0);
    chk(b_n, 1);
    chk(st_n, 0);
    t_rdy;
    t_regs;
    end_sim;
  end

  // hang guard, far beyond the few hundred cycles the scenarios need
  initial begin
    #300000;
    n_fail++;
    end_sim;
  end
endmodule // tb_ext_bus_cycle_timing
